/* logic/rdc_pkg.sv */
// Shared constants and types for the control-pin decode block
package rdc_pkg;

  typedef enum logic [1:0] {
    LVL_STRONG_LO = 2'h0,
    LVL_WEAK_LO   = 2'h1,
    LVL_OPEN      = 2'h3,
    LVL_STRONG_HI = 2'h2
  } rdc_level_t;

  typedef enum logic [1:0] {
    MODE_PIN    = 2'h0,
    MODE_EEPROM = 2'h1,
    MODE_TARGET = 2'h3
  } rdc_mode_t;

  typedef enum logic [1:0] {
    RATE_GEN12    = 2'h0,
    RATE_AUTO     = 2'h1,
    RATE_GEN3_NDE = 2'h3,
    RATE_GEN3_DE  = 2'h2
  } rdc_rate_t;

  typedef enum logic [2:0] {
    LD_IDLE  = 3'h0,
    LD_START = 3'h1,
    LD_BIT   = 3'h3,
    LD_STOP  = 3'h2,
    LD_DONE  = 3'h6
  } rdc_load_t;

  // Comparator thermometer patterns of a four-level pin
  localparam logic [2:0] THERMO_STRONG_LO = 3'h0;
  localparam logic [2:0] THERMO_WEAK_LO   = 3'h1;
  localparam logic [2:0] THERMO_OPEN      = 3'h3;
  localparam logic [2:0] THERMO_STRONG_HI = 3'h7;
  localparam int unsigned THERMO_LOGIC_BIT = 1;

  localparam int unsigned NUM_CHAN   = 8;
  localparam int unsigned BANK_SIZE  = 4;
  localparam int unsigned NUM_PINS   = 12;
  localparam int unsigned STRAP_STABLE_CYC = 4;

  // Four-level pin slots
  localparam int unsigned PIN_MODE  = 0;
  localparam int unsigned PIN_RATE  = 1;
  localparam int unsigned PIN_SDTH  = 2;
  localparam int unsigned PIN_RECEIVER_DETECT_CONTROL = 3;
  localparam int unsigned PIN_EQA0  = 4;
  localparam int unsigned PIN_EQA1  = 5;
  localparam int unsigned PIN_EQB0  = 6;
  localparam int unsigned PIN_EQB1  = 7;
  localparam int unsigned PIN_DEMA0 = 8;
  localparam int unsigned PIN_DEMA1 = 9;
  localparam int unsigned PIN_DEMB0 = 10;
  localparam int unsigned PIN_DEMB1 = 11;

  // Load clock timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SCL_HALF_NS   = 5000;
  localparam int unsigned SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [3:0] LOAD_BYTES  = 4'h8;
  localparam logic [3:0] ACK_BIT     = 4'h8;

  // Register word addresses and fields
  localparam logic [3:0] REG_CHAN0   = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h8;
  localparam logic [3:0] REG_ADDRESS = 4'h9;
  localparam int unsigned CHAN_EQ_LSB  = 0;
  localparam int unsigned CHAN_DEM_LSB = 4;
  localparam logic [7:0] CHAN_RESET    = 8'h00;
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_RATE_LSB   = 2;
  localparam int unsigned ST_BUSY_BIT   = 4;
  localparam int unsigned ST_FAIL_BIT   = 5;
  localparam int unsigned ST_POWER_DOWN_INPUT_BIT   = 6;
  localparam int unsigned ST_TERM_BIT   = 7;

endpackage

/* logic/rdc_level_decode.sv */
// Four-level strap resolver with a stability filter
`timescale 1ns/1ns
`default_nettype none
module rdc_level_decode #(
  parameter int unsigned STABLE_CYC = rdc_pkg::STRAP_STABLE_CYC
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic [2:0]       thermo_in,
  output var  rdc_pkg::rdc_level_t code_out
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  logic              valid;
  rdc_pkg::rdc_level_t raw;
  rdc_pkg::rdc_level_t cand_q;
  logic [CW-1:0]     cnt_q;

  always_comb begin
    valid = 1'b1;
    case (thermo_in)
      rdc_pkg::THERMO_STRONG_LO: raw = rdc_pkg::LVL_STRONG_LO;
      rdc_pkg::THERMO_WEAK_LO:   raw = rdc_pkg::LVL_WEAK_LO;
      rdc_pkg::THERMO_OPEN:      raw = rdc_pkg::LVL_OPEN;
      rdc_pkg::THERMO_STRONG_HI: raw = rdc_pkg::LVL_STRONG_HI;
      default: begin
        raw   = cand_q;
        valid = 1'b0;
      end
    endcase
  end

  // Code changes only after a steady level, so slow edges cannot flash a mode
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cand_q   <= rdc_pkg::LVL_STRONG_LO;
      cnt_q    <= '0;
      code_out <= rdc_pkg::LVL_STRONG_LO;
    end else if (ce_in && valid) begin
      if (raw != cand_q) begin
        cand_q <= raw;
        cnt_q  <= '0;
      end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
        code_out <= cand_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  a_code_settled : assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (code_out != $past(code_out)) |-> ($past(cnt_q) == CW'(STABLE_CYC - 1) && code_out == $past(cand_q)))
    else $error("strap code changed before settling");

endmodule
`default_nettype wire

/* logic/rdc_pin_decode.sv */
// Control-pin decode, mode selection and configuration load engine
`timescale 1ns/1ns
`default_nettype none
module rdc_pin_decode #(
  parameter int unsigned HALF_CYC   = rdc_pkg::SCL_HALF_CYC,
  parameter int unsigned STABLE_CYC = rdc_pkg::STRAP_STABLE_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [2:0]  lvl_mgmt_bus_mode_select_in,
  input  wire logic [2:0]  lvl_rate_mode_in,
  input  wire logic [2:0]  lvl_signal_detect_threshold_in,
  input  wire logic [2:0]  lvl_receiver_detect_control_in,
  input  wire logic [2:0]  lvl_bank_a_equalization_level0_in,
  input  wire logic [2:0]  lvl_bank_a_equalization_level1_in,
  input  wire logic [2:0]  lvl_bank_b_equalization_level0_in,
  input  wire logic [2:0]  lvl_bank_b_equalization_level1_in,
  input  wire logic [2:0]  lvl_bank_a_deemphasis_level0_in,
  input  wire logic [2:0]  lvl_bank_a_deemphasis_level1_in,
  input  wire logic [2:0]  lvl_bank_b_deemphasis_level0_in,
  input  wire logic [2:0]  lvl_bank_b_deemphasis_level1_in,
  input  wire logic        eeprom_load_trigger_in,
  input  wire logic        power_down_input_in,
  output logic             mgmt_data_out,
  output logic             mgmt_data_oe_out,
  output logic             mgmt_clock_out,
  output logic             mgmt_clock_oe_out,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  output logic [1:0]       mgmt_mode_out,
  output logic [3:0]       target_address_out,
  output logic [31:0]      chan_eq_out,
  output logic [31:0]      chan_dem_out,
  output logic [1:0]       rate_mode_out,
  output logic [1:0]       sd_threshold_out,
  output logic             term_50_ohm_out,
  output logic             powered_down_out,
  output logic             load_status_out,
  output logic             load_busy_out
);

  localparam int unsigned DW = $clog2(HALF_CYC + 1);

  function automatic logic rdc_sda_low(input logic tx, input logic [3:0] bitn,
                                       input logic last, input logic txbit);
    if (bitn == rdc_pkg::ACK_BIT)
      return tx ? 1'b0 : ~last;
    return tx ? ~txbit : 1'b0;
  endfunction

  function automatic logic rdc_is_hi(input rdc_pkg::rdc_level_t c);
    return c == rdc_pkg::LVL_STRONG_HI;
  endfunction

  logic [2:0]          thermo [rdc_pkg::NUM_PINS];
  rdc_pkg::rdc_level_t code   [rdc_pkg::NUM_PINS];
  rdc_pkg::rdc_mode_t  mode;
  rdc_pkg::rdc_rate_t  rate;
  logic [3:0]          addr_now;
  logic [3:0]          bank_a_eq;
  logic [3:0]          bank_b_eq;
  logic [3:0]          bank_a_dem;
  logic [3:0]          bank_b_dem;
  logic [7:0]          chan_q [rdc_pkg::NUM_CHAN];
  logic                trig_prev_q;
  logic                load_start;
  rdc_pkg::rdc_load_t  ld_state_q;
  logic [DW-1:0]       div_q;
  logic                tick;
  logic                half_q;
  logic [3:0]          bit_q;
  logic [3:0]          byte_q;
  logic [7:0]          shift_q;
  logic                fail_q;
  logic                scl_low_q;
  logic                sda_low_q;
  logic                sda_level;
  logic                last_bit;
  logic [3:0]          nxt_bit;
  logic [3:0]          nxt_byte;
  logic [7:0]          nxt_shift;
  logic                nxt_sda_low;
  logic [7:0]          status;

  assign thermo[rdc_pkg::PIN_MODE]  = lvl_mgmt_bus_mode_select_in;
  assign thermo[rdc_pkg::PIN_RATE]  = lvl_rate_mode_in;
  assign thermo[rdc_pkg::PIN_SDTH]  = lvl_signal_detect_threshold_in;
  assign thermo[rdc_pkg::PIN_RECEIVER_DETECT_CONTROL] = lvl_receiver_detect_control_in;
  assign thermo[rdc_pkg::PIN_EQA0]  = lvl_bank_a_equalization_level0_in;
  assign thermo[rdc_pkg::PIN_EQA1]  = lvl_bank_a_equalization_level1_in;
  assign thermo[rdc_pkg::PIN_EQB0]  = lvl_bank_b_equalization_level0_in;
  assign thermo[rdc_pkg::PIN_EQB1]  = lvl_bank_b_equalization_level1_in;
  assign thermo[rdc_pkg::PIN_DEMA0] = lvl_bank_a_deemphasis_level0_in;
  assign thermo[rdc_pkg::PIN_DEMA1] = lvl_bank_a_deemphasis_level1_in;
  assign thermo[rdc_pkg::PIN_DEMB0] = lvl_bank_b_deemphasis_level0_in;
  assign thermo[rdc_pkg::PIN_DEMB1] = lvl_bank_b_deemphasis_level1_in;

  for (genvar p = 0; p < rdc_pkg::NUM_PINS; p++) begin : g_pin
    rdc_level_decode #(
      .STABLE_CYC (STABLE_CYC)
    ) u_dec (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .thermo_in  (thermo[p]),
      .code_out   (code[p])
    );
  end

  // Strap decode; weak pull-down on the mode pin is undefined, kept as pin mode
  always_comb begin
    case (code[rdc_pkg::PIN_MODE])
      rdc_pkg::LVL_STRONG_HI: mode = rdc_pkg::MODE_TARGET;
      rdc_pkg::LVL_OPEN:      mode = rdc_pkg::MODE_EEPROM;
      default:                mode = rdc_pkg::MODE_PIN;
    endcase
    case (code[rdc_pkg::PIN_RATE])
      rdc_pkg::LVL_STRONG_LO: rate = rdc_pkg::RATE_GEN12;
      rdc_pkg::LVL_OPEN:      rate = rdc_pkg::RATE_AUTO;
      rdc_pkg::LVL_WEAK_LO:   rate = rdc_pkg::RATE_GEN3_NDE;
      default:                rate = rdc_pkg::RATE_GEN3_DE;
    endcase
    // Shared pins: address bits lean on the board strapping them hard
    addr_now = {rdc_is_hi(code[rdc_pkg::PIN_EQB0]), rdc_is_hi(code[rdc_pkg::PIN_EQB1]),
                rdc_is_hi(code[rdc_pkg::PIN_DEMB0]), rdc_is_hi(code[rdc_pkg::PIN_DEMB1])};
    bank_a_eq  = {code[rdc_pkg::PIN_EQA1], code[rdc_pkg::PIN_EQA0]};
    bank_b_eq  = {code[rdc_pkg::PIN_EQB1], code[rdc_pkg::PIN_EQB0]};
    bank_a_dem = {code[rdc_pkg::PIN_DEMA1], code[rdc_pkg::PIN_DEMA0]};
    bank_b_dem = {code[rdc_pkg::PIN_DEMB1], code[rdc_pkg::PIN_DEMB0]};
  end

  // Decoded configuration outputs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mgmt_mode_out      <= rdc_pkg::MODE_PIN;
      target_address_out <= 4'h0;
      rate_mode_out      <= rdc_pkg::RATE_GEN12;
      sd_threshold_out   <= rdc_pkg::LVL_STRONG_LO;
      term_50_ohm_out    <= 1'b0;
      powered_down_out   <= 1'b0;
    end else if (ce_in) begin
      mgmt_mode_out <= mode;
      if (mode != rdc_pkg::MODE_PIN) begin
        target_address_out <= addr_now;
      end
      rate_mode_out    <= rate;
      sd_threshold_out <= code[rdc_pkg::PIN_SDTH];
      // Only a hard pull-down selects the high-impedance load
      term_50_ohm_out  <= code[rdc_pkg::PIN_RECEIVER_DETECT_CONTROL] != rdc_pkg::LVL_STRONG_LO;
      powered_down_out <= power_down_input_in;
    end
  end

  // Per-channel levels: straps by bank in pin mode, registers otherwise
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      chan_eq_out  <= 32'h0;
      chan_dem_out <= 32'h0;
    end else if (ce_in) begin
      for (int c = 0; c < rdc_pkg::NUM_CHAN; c++) begin
        if (mode == rdc_pkg::MODE_PIN) begin
          chan_eq_out[c*4 +: 4]  <= (c < rdc_pkg::BANK_SIZE) ? bank_a_eq : bank_b_eq;
          chan_dem_out[c*4 +: 4] <= (c < rdc_pkg::BANK_SIZE) ? bank_a_dem : bank_b_dem;
        end else begin
          chan_eq_out[c*4 +: 4]  <= chan_q[c][rdc_pkg::CHAN_EQ_LSB +: 4];
          chan_dem_out[c*4 +: 4] <= chan_q[c][rdc_pkg::CHAN_DEM_LSB +: 4];
        end
      end
    end
  end

  // Load trigger edge detect; inputs are already synchronous
  assign load_start = trig_prev_q && !eeprom_load_trigger_in && mode == rdc_pkg::MODE_EEPROM
                      && ld_state_q == rdc_pkg::LD_IDLE;
  assign tick       = div_q == DW'(HALF_CYC - 1);
  assign sda_level  = lvl_bank_a_deemphasis_level0_in[rdc_pkg::THERMO_LOGIC_BIT];

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      trig_prev_q <= 1'b1;
    end else if (ce_in) begin
      trig_prev_q <= eeprom_load_trigger_in;
    end
  end

  always_comb begin
    last_bit    = bit_q == rdc_pkg::ACK_BIT;
    nxt_bit     = last_bit ? 4'h0 : bit_q + 4'h1;
    nxt_byte    = last_bit ? byte_q + 4'h1 : byte_q;
    nxt_shift   = {shift_q[6:0], (byte_q == 4'h0) ? 1'b0 : sda_level};
    nxt_sda_low = rdc_sda_low(nxt_byte == 4'h0, nxt_bit, nxt_byte == rdc_pkg::LOAD_BYTES, nxt_shift[7]);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !load_busy_out) begin
      div_q <= '0;
    end else if (ce_in) begin
      div_q <= tick ? '0 : div_q + DW'(1);
    end
  end

  // Load engine: start, address byte, data bytes with master ack except a nack on the last, stop
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ld_state_q <= rdc_pkg::LD_IDLE;
      half_q     <= 1'b0;
      bit_q      <= 4'h0;
      byte_q     <= 4'h0;
      shift_q    <= 8'h00;
      fail_q     <= 1'b0;
      scl_low_q  <= 1'b0;
      sda_low_q  <= 1'b0;
    end else if (ce_in) begin
      case (ld_state_q)
        rdc_pkg::LD_IDLE: begin
          scl_low_q <= 1'b0;
          sda_low_q <= 1'b0;
          if (load_start) begin
            ld_state_q <= rdc_pkg::LD_START;
            half_q     <= 1'b0;
            fail_q     <= 1'b0;
          end
        end
        rdc_pkg::LD_START: begin
          if (tick && !half_q) begin
            sda_low_q <= 1'b1;
            half_q    <= 1'b1;
          end else if (tick) begin
            scl_low_q  <= 1'b1;
            half_q     <= 1'b0;
            bit_q      <= 4'h0;
            byte_q     <= 4'h0;
            shift_q    <= {rdc_pkg::EE_DEV_ADDR, 1'b1};
            sda_low_q  <= rdc_sda_low(1'b1, 4'h0, 1'b0, rdc_pkg::EE_DEV_ADDR[6]);
            ld_state_q <= rdc_pkg::LD_BIT;
          end
        end
        rdc_pkg::LD_BIT: begin
          if (tick && !half_q) begin
            scl_low_q <= 1'b0;
            half_q    <= 1'b1;
          end else if (tick) begin
            scl_low_q <= 1'b1;
            half_q    <= 1'b0;
            if (!last_bit) begin
              shift_q <= nxt_shift;
            end
            bit_q     <= nxt_bit;
            byte_q    <= nxt_byte;
            sda_low_q <= nxt_sda_low;
            // No answer to the address byte means no device fitted
            if (last_bit && (byte_q == 4'h0 && sda_level || byte_q == rdc_pkg::LOAD_BYTES)) begin
              fail_q     <= byte_q == 4'h0;
              sda_low_q  <= 1'b1;
              ld_state_q <= rdc_pkg::LD_STOP;
            end
          end
        end
        rdc_pkg::LD_STOP: begin
          if (tick && !half_q) begin
            scl_low_q <= 1'b0;
            half_q    <= 1'b1;
          end else if (tick) begin
            sda_low_q  <= 1'b0;
            ld_state_q <= rdc_pkg::LD_DONE;
          end
        end
        rdc_pkg::LD_DONE: begin
          ld_state_q <= rdc_pkg::LD_IDLE;
        end
        default: begin
          ld_state_q <= rdc_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // High until a load passes; a new load shows high again while it runs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      load_status_out <= 1'b1;
    end else if (ce_in) begin
      if (load_start) begin
        load_status_out <= 1'b1;
      end else if (ld_state_q == rdc_pkg::LD_DONE) begin
        load_status_out <= fail_q;
      end
    end
  end

  assign load_busy_out     = ld_state_q != rdc_pkg::LD_IDLE;
  assign mgmt_clock_out    = 1'b0;
  assign mgmt_clock_oe_out = scl_low_q;
  assign mgmt_data_out     = 1'b0;
  assign mgmt_data_oe_out  = sda_low_q;

  // Channel registers; a byte from the loader wins over a bus write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int c = 0; c < rdc_pkg::NUM_CHAN; c++) begin
        chan_q[c] <= rdc_pkg::CHAN_RESET;
      end
    end else if (ce_in) begin
      if (ld_state_q == rdc_pkg::LD_BIT && tick && half_q && last_bit && byte_q != 4'h0) begin
        chan_q[3'(byte_q - 4'h1)] <= shift_q;
      end else if (reg_wr_in && !reg_addr_in[3]) begin
        chan_q[reg_addr_in[2:0]] <= reg_wdata_in;
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[rdc_pkg::ST_MODE_LSB +: 2] = mgmt_mode_out;
    status[rdc_pkg::ST_RATE_LSB +: 2] = rate_mode_out;
    status[rdc_pkg::ST_BUSY_BIT]      = load_busy_out;
    status[rdc_pkg::ST_FAIL_BIT]      = load_status_out;
    status[rdc_pkg::ST_POWER_DOWN_INPUT_BIT]      = powered_down_out;
    status[rdc_pkg::ST_TERM_BIT]      = term_50_ohm_out;
  end

  // Read data stands one cycle only; unmapped words read zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      if (!reg_rd_in) begin
        reg_rdata_out <= 8'h00;
      end else if (!reg_addr_in[3]) begin
        reg_rdata_out <= chan_q[reg_addr_in[2:0]];
      end else if (reg_addr_in == rdc_pkg::REG_STATUS) begin
        reg_rdata_out <= status;
      end else if (reg_addr_in == rdc_pkg::REG_ADDRESS) begin
        reg_rdata_out <= {4'h0, target_address_out};
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_addr_from_straps : assert property (
    ce_in && mode != rdc_pkg::MODE_PIN |=> target_address_out == $past(addr_now))
    else $error("target address not taken from straps");

  a_addr_shared_pins : assert property (
    ce_in && mode == rdc_pkg::MODE_TARGET |=> target_address_out[3:2] ==
      {$past(code[rdc_pkg::PIN_EQB0]) == rdc_pkg::LVL_STRONG_HI,
       $past(code[rdc_pkg::PIN_EQB1]) == rdc_pkg::LVL_STRONG_HI})
    else $error("address bits 3:2 not from bank B equalization pins");

  a_load_on_fall : assert property (
    ce_in && $past(ce_in) && mode == rdc_pkg::MODE_EEPROM && ld_state_q == rdc_pkg::LD_IDLE
      && $fell(eeprom_load_trigger_in) |=> ld_state_q == rdc_pkg::LD_START && load_status_out)
    else $error("falling trigger did not start a load");

  a_eq_pin_banks : assert property (
    ce_in && mode == rdc_pkg::MODE_PIN |=> chan_eq_out[3:0] == $past(bank_a_eq)
      && chan_eq_out[31:28] == $past(bank_b_eq))
    else $error("pin mode equalization not from bank straps");

  a_dem_pin_banks : assert property (
    ce_in && mode == rdc_pkg::MODE_PIN |=> chan_dem_out[15:12] == $past(bank_a_dem)
      && chan_dem_out[19:16] == $past(bank_b_dem))
    else $error("pin mode de-emphasis not from bank straps");

  a_reg_levels : assert property (
    ce_in && mode != rdc_pkg::MODE_PIN |=> chan_eq_out[7:4] == $past(chan_q[1][3:0])
      && chan_dem_out[31:28] == $past(chan_q[7][7:4]))
    else $error("register levels not applied per channel");

  a_rate_decode : assert property (
    ce_in && code[rdc_pkg::PIN_RATE] == rdc_pkg::LVL_WEAK_LO |=> rate_mode_out == rdc_pkg::RATE_GEN3_NDE)
    else $error("weak pull-down rate strap misdecoded");

  a_term_select : assert property (
    ce_in && code[rdc_pkg::PIN_RECEIVER_DETECT_CONTROL] == rdc_pkg::LVL_STRONG_LO |=> !term_50_ohm_out)
    else $error("termination select wrong");

  a_power_down : assert property (
    ce_in |=> powered_down_out == $past(power_down_input_in))
    else $error("power-down input not followed");

  a_status_result : assert property (
    ce_in && ld_state_q == rdc_pkg::LD_DONE |=> load_status_out == $past(fail_q) && !load_busy_out)
    else $error("load status does not match result");

  a_clock_released : assert property (
    ld_state_q == rdc_pkg::LD_IDLE && $past(ld_state_q) == rdc_pkg::LD_IDLE |-> !mgmt_clock_oe_out)
    else $error("clock driven outside a load");

endmodule
`default_nettype wire

/* verification/rdc_eeprom_model.sv */
// Configuration memory model on the open-drain management pair
`timescale 1ns/1ns
`default_nettype none
module rdc_eeprom_model (
  input  wire logic ack_en_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_low_out
);
  int unsigned rises = 0;
  initial sda_low_out = 1'b0;
  always @(posedge scl_in) rises++;
  // Start condition rewinds the bit count; data moving with the falling clock is no start
  always @(negedge sda_in) #1 if (scl_in) rises = 0;
  // Acks the address only; released bits read back as ones, so every byte is 0xFF
  always @(negedge scl_in) sda_low_out <= ack_en_in && rises == 8;
endmodule
`default_nettype wire

/* verification/redriver_control_pin_decode_tb.sv */
// Self-checking bench for the control-pin decode block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module redriver_control_pin_decode_tb;
  logic        clk = 0, rst = 1, trig = 1, power_down_input = 0, wr = 0, rd = 0, bus_on = 0, ack_en = 0;
  logic        ce = 1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic [2:0]  th [12] = '{default: 3'h0};
  logic        d_oe, c_oe, ee_low, busy, status, pd, term, d_o, c_o;
  logic [7:0]  rdata;
  logic [1:0]  mode, rate, sdth;
  logic [3:0]  taddr;
  logic [31:0] eq, dem;
  wire         sda = ~(d_oe | ee_low);
  wire         scl = ~c_oe;
  int          num_errors = 0, n_tests = 0;
  // Rows: mode, rate, rx-detect thermometers; mode, rate, termination expected
  logic [13:0] rows [4] = '{{3'h0, 3'h0, 3'h0, 2'h0, 2'h0, 1'h0}, {3'h1, 3'h1, 3'h1, 2'h0, 2'h3, 1'h1},
                            {3'h0, 3'h3, 3'h3, 2'h0, 2'h1, 1'h1}, {3'h0, 3'h7, 3'h7, 2'h0, 2'h2, 1'h1}};
  always #50 clk = ~clk;
  rdc_pin_decode #(.HALF_CYC(2), .STABLE_CYC(1)) dut (
    .sys_clk_in(clk), .rst_in(rst), .ce_in(ce), .lvl_mgmt_bus_mode_select_in(th[0]),
    .lvl_rate_mode_in(th[1]), .lvl_signal_detect_threshold_in(th[2]), .lvl_receiver_detect_control_in(th[3]),
    .lvl_bank_a_equalization_level0_in(th[4]), .lvl_bank_a_equalization_level1_in(th[5]),
    .lvl_bank_b_equalization_level0_in(th[6]), .lvl_bank_b_equalization_level1_in(th[7]),
    .lvl_bank_a_deemphasis_level0_in(bus_on ? {3{sda}} : th[8]),
    .lvl_bank_a_deemphasis_level1_in(bus_on ? {3{scl}} : th[9]),
    .lvl_bank_b_deemphasis_level0_in(th[10]), .lvl_bank_b_deemphasis_level1_in(th[11]),
    .eeprom_load_trigger_in(trig), .power_down_input_in(power_down_input), .mgmt_data_out(d_o), .mgmt_data_oe_out(d_oe),
    .mgmt_clock_out(c_o), .mgmt_clock_oe_out(c_oe), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .mgmt_mode_out(mode), .target_address_out(taddr),
    .chan_eq_out(eq), .chan_dem_out(dem), .rate_mode_out(rate), .sd_threshold_out(sdth),
    .term_50_ohm_out(term), .powered_down_out(pd), .load_status_out(status), .load_busy_out(busy));
  rdc_eeprom_model ee (.ack_en_in(ack_en), .scl_in(scl), .sda_in(sda), .sda_low_out(ee_low));
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  task automatic run_load();
    @(posedge clk);
    trig <= 1'b0;
    tick(3);
    `CHK("busy", 1'b1, busy)
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    `CHK("done", 1'b0, busy)
    trig <= 1'b1;
    tick(2);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    `CHK("status", 1'b1, status)
    // Pin-mode bank straps, held through the table
    th[4] <= 3'h1; th[5] <= 3'h7; th[6] <= 3'h3; th[7] <= 3'h0;
    th[8] <= 3'h7; th[9] <= 3'h3; th[10] <= 3'h0; th[11] <= 3'h1;
    foreach (rows[i]) begin
      {th[0], th[1], th[3]} <= rows[i][13:5];
      tick(5);
      `CHK("mode", rows[i][4:3], mode)
      `CHK("rate", rows[i][2:1], rate)
      `CHK("term", rows[i][0], term)
      `CHK("eq", 32'h3333_9999, eq)
      `CHK("dem", 32'h4444_EEEE, dem)
    end
    // Loader mode: first attempt gets no ack and must fail
    bus_on <= 1'b1;
    th[0] <= 3'h3;
    th[2] <= 3'h7;
    tick(5);
    `CHK("mode", 2'h1, mode)
    `CHK("sdth", 2'h2, sdth)
    run_load();
    `CHK("status", 1'b1, status)
    ack_en <= 1'b1;
    run_load();
    `CHK("status", 1'b0, status)
    `CHK("clk_oe", 1'b0, c_oe)
    `CHK("eq", 32'hFFFF_FFFF, eq)
    // Target mode: straps now form the address, not levels
    th[0] <= 3'h7; th[6] <= 3'h7; th[7] <= 3'h0; th[10] <= 3'h7; th[11] <= 3'h0;
    tick(5);
    `CHK("addr", 4'hA, taddr)
    `CHK("eq", 32'hFFFF_FFFF, eq)
    wr_reg(4'h0, 8'h5A);
    wr_reg(4'h9, 8'h33);
    rd_reg(4'h0, 8'h5A);
    `CHK("eq0", 8'hFA, eq[7:0])
    rd_reg(4'h9, 8'h0A);
    rd_reg(4'hC, 8'h00);
    rd_reg(4'h8, 8'h8B);
    `CHK("od", 2'h0, {d_o, c_o})
    // Enable low must freeze the power-down flop
    tick(1);
    ce <= 1'b0;
    power_down_input <= 1'b1;
    tick(3);
    `CHK("pd", 1'b0, pd)
    ce <= 1'b1;
    tick(3);
    `CHK("pd", 1'b1, pd)
    close_out();
  end
endmodule
`default_nettype wire
